// ---- core/rfsup_map.svh ----
// Purpose: constants for the regulator fault supervisor
// Assumes: comparator thresholds are set in the analog domain
// Notes: counts are in switching cycles
`ifndef RFSUP_MAP_SVH
`define RFSUP_MAP_SVH
`define RFSUP_UV_PERCENT     16
`define RFSUP_OV_PERCENT     116
`define RFSUP_OC_AMPS        11
`define RFSUP_OT_TRIP_DEGC   150
`define RFSUP_OT_CLEAR_DEGC  135
`define RFSUP_OC_CYCLES      4'h8
`define RFSUP_OC_CNT_W       4
`endif

// ---- core/rfsup_pkg.sv ----
// Purpose: types for the regulator fault supervisor
// Assumes: included map header supplies widths
// Notes: state is one packed struct
`include "rfsup_map.svh"
package rfsup_pkg;
	typedef enum logic [1:0] {
		RFSUP_RUN   = 2'b00,
		RFSUP_OFF   = 2'b01,
		RFSUP_OVP   = 2'b10,
		RFSUP_IDLE  = 2'b11
	} rfsup_mode_e;

	typedef struct packed {
		logic uv;
		logic ov;
		logic oc_valley;
		logic oc_high;
		logic hot;
		logic hot_clear;
	} rfsup_sense_s;

	typedef struct packed {
		rfsup_mode_e                 mode;
		logic [`RFSUP_OC_CNT_W-1:0]  oc_cnt;
		logic                        uv_f;
		logic                        oc_f;
		logic                        hs_f;
		logic                        ot_f;
		logic                        ov_f;
		logic                        hot_seen;
		logic                        pg;
		logic                        hs_on;
		logic                        ls_on;
		logic                        dis_on;
	} rfsup_state_s;
endpackage

// ---- core/rfsup_top.sv ----
// Purpose: latch regulator faults and drive power-good, switch gating, discharge
// Assumes: all sense inputs are asynchronous comparator levels
// Notes: cycle_strobe marks one switching cycle
`timescale 1ns/1ps
`include "rfsup_map.svh"

// Summary of operation
// - output below 84% of target while running: power-good low, both switches off, discharge on
// - undervoltage fault held until reset or enable toggle
// - output above 116% of target: power-good low, enter overvoltage state
// - in overvoltage state high-side switch stays off until cleared
// - in overvoltage state low-side follows output above target, repeatedly
// - overvoltage state left only by reset or enable recycle
// - each switching cycle compare valley current against 11A threshold
// - eight consecutive valley trips: fault, power-good low, switches off, discharge
// - high-side catastrophic overcurrent latches switches off, discharge, power-good low
// - die above 150C suspends switching and shuts down
// - after thermal trip resume only below 135C and then toggle; reset resumes unless above 150C
// - power-good high only with supplies good, enabled and no fault
// - discharge on when disabled or any latched fault except overvoltage
module rfsup_top (
	// clock and reset
	input  wire logic CLOCK,
	input  wire logic RESETN,
	// system controls
	input  wire logic ENABLE,
	input  wire logic SUPPLY_GOOD,
	input  wire logic POWER_STAGE_SUPPLY_GOOD,
	// comparators and PWM request
	input  wire logic CYCLE_STROBE,
	input  wire logic UNDER_VOLTAGE,
	input  wire logic OVER_VOLTAGE,
	input  wire logic ABOVE_TARGET,
	input  wire logic OVERCURRENT_TRIP,
	input  wire logic HIGH_SIDE_OVERCURRENT,
	input  wire logic DIE_HOT,
	input  wire logic DIE_COOLED,
	input  wire logic PWM_REQUEST,
	// outputs
	output logic      POWER_GOOD_OUT,
	output logic      HIGH_SIDE_ON,
	output logic      LOW_SIDE_ON,
	output logic      SOFT_DISCHARGE_ON
);
	localparam int NSYNC = 12;
	logic [NSYNC-1:0] s1_reg;
	logic [NSYNC-1:0] s2_reg;
	logic [NSYNC-1:0] raw;
	logic             cyc_d_reg;
	logic             cyc_pulse;
	rfsup_pkg::rfsup_state_s st_reg;
	rfsup_pkg::rfsup_state_s st_next;
	logic en, sup_ok, uv, ov, above, oc, hsoc, hot, cool, pwm;

	assign raw = {ENABLE, SUPPLY_GOOD, POWER_STAGE_SUPPLY_GOOD, CYCLE_STROBE, UNDER_VOLTAGE,
		OVER_VOLTAGE, ABOVE_TARGET, OVERCURRENT_TRIP, HIGH_SIDE_OVERCURRENT, DIE_HOT,
		DIE_COOLED, PWM_REQUEST};

	// two-flop synchronisers, one per input bit
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge CLOCK or negedge RESETN) begin
				if (!RESETN) begin
					s1_reg[gi] <= 1'b0;
					s2_reg[gi] <= 1'b0;
				end else begin
					s1_reg[gi] <= raw[gi];
					s2_reg[gi] <= s1_reg[gi];
				end
			end
		end
	endgenerate

	assign en     = s2_reg[11];
	assign sup_ok = s2_reg[10] & s2_reg[9];
	assign uv     = s2_reg[7];
	assign ov     = s2_reg[6];
	assign above  = s2_reg[5];
	assign oc     = s2_reg[4];
	assign hsoc   = s2_reg[3];
	assign hot    = s2_reg[2];
	assign cool   = s2_reg[1];
	assign pwm    = s2_reg[0];

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			cyc_d_reg <= 1'b0;
		end else begin
			cyc_d_reg <= s2_reg[8];
		end
	end
	assign cyc_pulse = s2_reg[8] & ~cyc_d_reg;

	always_comb begin
		logic fault_any;
		fault_any = 1'b0;
		st_next = st_reg;
		// valley current sampled once per switching cycle
		if (cyc_pulse) begin
			if (oc) begin
				if (st_reg.oc_cnt != `RFSUP_OC_CYCLES) begin
					st_next.oc_cnt = st_reg.oc_cnt + 4'h1;
				end
			end else begin
				st_next.oc_cnt = '0;
			end
		end
		if (st_next.oc_cnt == `RFSUP_OC_CYCLES) st_next.oc_f = 1'b1;
		if (uv && st_reg.mode == rfsup_pkg::RFSUP_RUN) st_next.uv_f = 1'b1;
		if (hsoc) st_next.hs_f = 1'b1;
		if (hot) begin
			st_next.ot_f = 1'b1;
			st_next.hot_seen = 1'b1;
		end
		if (cool && !hot) st_next.hot_seen = 1'b0;
		if (ov) st_next.ov_f = 1'b1;
		// enable low clears every latch; thermal stays until the die has cooled
		if (!en) begin
			st_next.uv_f   = 1'b0;
			st_next.oc_f   = 1'b0;
			st_next.hs_f   = 1'b0;
			st_next.ov_f   = 1'b0;
			st_next.oc_cnt = '0;
			if (!st_next.hot_seen) st_next.ot_f = 1'b0;
		end
		fault_any = st_next.uv_f | st_next.oc_f | st_next.hs_f | st_next.ot_f;
		if (!en || !sup_ok) st_next.mode = rfsup_pkg::RFSUP_IDLE;
		else if (fault_any) st_next.mode = rfsup_pkg::RFSUP_OFF;
		else if (st_next.ov_f) st_next.mode = rfsup_pkg::RFSUP_OVP;
		else st_next.mode = rfsup_pkg::RFSUP_RUN;
		st_next.pg = en & sup_ok & ~fault_any & ~st_next.ov_f;
		st_next.dis_on = ~en | fault_any;
		case (st_next.mode)
			rfsup_pkg::RFSUP_RUN: begin
				st_next.hs_on = pwm;
				st_next.ls_on = ~pwm;
			end
			rfsup_pkg::RFSUP_OVP: begin
				st_next.hs_on = 1'b0;
				st_next.ls_on = above;
			end
			default: begin
				st_next.hs_on = 1'b0;
				st_next.ls_on = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			st_reg <= '{mode: rfsup_pkg::RFSUP_IDLE, oc_cnt: '0, dis_on: 1'b1, default: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign POWER_GOOD_OUT    = st_reg.pg;
	assign HIGH_SIDE_ON      = st_reg.hs_on;
	assign LOW_SIDE_ON       = st_reg.ls_on;
	assign SOFT_DISCHARGE_ON = st_reg.dis_on;

	property p_uv_off;
		@(posedge CLOCK) disable iff (!RESETN)
		st_reg.uv_f |-> !POWER_GOOD_OUT && !HIGH_SIDE_ON && !LOW_SIDE_ON && SOFT_DISCHARGE_ON;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("undervoltage outputs wrong");
	property p_uv_hold;
		@(posedge CLOCK) disable iff (!RESETN)
		st_reg.uv_f && en |=> st_reg.uv_f;
	endproperty
	a_uv_hold: assert property (p_uv_hold) else $error("undervoltage latch dropped");
	property p_ov_pg;
		@(posedge CLOCK) disable iff (!RESETN)
		ov && en |-> ##2 !POWER_GOOD_OUT;
	endproperty
	a_ov_pg: assert property (p_ov_pg) else $error("power good high in overvoltage");
	property p_ov_hs;
		@(posedge CLOCK) disable iff (!RESETN)
		st_reg.ov_f |-> !HIGH_SIDE_ON;
	endproperty
	a_ov_hs: assert property (p_ov_hs) else $error("high side on in overvoltage");
	property p_ov_ls;
		@(posedge CLOCK) disable iff (!RESETN)
		st_next.mode == rfsup_pkg::RFSUP_OVP |=> LOW_SIDE_ON == $past(above);
	endproperty
	a_ov_ls: assert property (p_ov_ls) else $error("low side not following output");
	property p_ov_keep;
		@(posedge CLOCK) disable iff (!RESETN)
		st_reg.ov_f && en |=> st_reg.ov_f;
	endproperty
	a_ov_keep: assert property (p_ov_keep) else $error("overvoltage left early");
	property p_oc_cnt;
		@(posedge CLOCK) disable iff (!RESETN)
		cyc_pulse && !oc |=> st_reg.oc_cnt == 4'h0;
	endproperty
	a_oc_cnt: assert property (p_oc_cnt) else $error("valley counter not cleared");
	property p_oc_trip;
		@(posedge CLOCK) disable iff (!RESETN)
		st_reg.oc_cnt == `RFSUP_OC_CYCLES |-> st_reg.oc_f || !$past(en);
	endproperty
	a_oc_trip: assert property (p_oc_trip) else $error("overcurrent fault missed");
	property p_hs_trip;
		@(posedge CLOCK) disable iff (!RESETN)
		hsoc |=> !POWER_GOOD_OUT && !HIGH_SIDE_ON && !LOW_SIDE_ON;
	endproperty
	a_hs_trip: assert property (p_hs_trip) else $error("catastrophic trip slow");
	property p_hot;
		@(posedge CLOCK) disable iff (!RESETN)
		hot |=> !HIGH_SIDE_ON && !LOW_SIDE_ON;
	endproperty
	a_hot: assert property (p_hot) else $error("switching while hot");
	property p_pg;
		@(posedge CLOCK) disable iff (!RESETN)
		POWER_GOOD_OUT |-> $past(en) && $past(sup_ok);
	endproperty
	a_pg: assert property (p_pg) else $error("power good without enable");
	property p_dis;
		@(posedge CLOCK) disable iff (!RESETN)
		!en |=> SOFT_DISCHARGE_ON;
	endproperty
	a_dis: assert property (p_dis) else $error("discharge off while disabled");
endmodule // rfsup_top

// ---- testbench/rfsup_stage_model.sv ----
// Purpose: comparator side of the power stage
// Assumes: switching period of four clocks
// Notes: temperature is given in degrees
`timescale 1ns/1ps
`include "rfsup_map.svh"
module rfsup_stage_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// commands
	input  wire logic       valley_high,
	input  wire logic [7:0] temp_degc,
	// comparator levels
	output logic            strobe,
	output logic            trip,
	output logic            hot,
	output logic            cooled
);
	logic [1:0] phase_reg;
	// free-running switching period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end
	assign strobe = phase_reg[1];
	assign trip   = valley_high;
	// between the two thresholds neither level is set
	assign hot    = temp_degc > 8'(`RFSUP_OT_TRIP_DEGC);
	assign cooled = temp_degc < 8'(`RFSUP_OT_CLEAR_DEGC);
endmodule // rfsup_stage_model

// ---- testbench/rfsup_top_tb.sv ----
// Purpose: self-checking bench for the fault supervisor
// Assumes: outputs settle three clocks after an input change
// Notes: expected nibble is power good, high side, low side, discharge
`timescale 1ns/1ps
module rfsup_top_tb;
	logic       clk, rst_n, en, sup_ok, stage_ok, uv, ov, above, hs_oc, pwm, valley;
	logic [7:0] temp;
	logic       strobe, trip, hot, cooled, pg, hs, ls, dis;
	int         mismatches;
	int         checks;

	rfsup_stage_model rfsup_stage_model_i (.clk(clk), .rst_n(rst_n), .valley_high(valley),
		.temp_degc(temp), .strobe(strobe), .trip(trip), .hot(hot), .cooled(cooled));
	rfsup_top rfsup_top_i (.CLOCK(clk), .RESETN(rst_n), .ENABLE(en), .SUPPLY_GOOD(sup_ok),
		.POWER_STAGE_SUPPLY_GOOD(stage_ok), .CYCLE_STROBE(strobe), .UNDER_VOLTAGE(uv),
		.OVER_VOLTAGE(ov), .ABOVE_TARGET(above), .OVERCURRENT_TRIP(trip),
		.HIGH_SIDE_OVERCURRENT(hs_oc), .DIE_HOT(hot), .DIE_COOLED(cooled), .PWM_REQUEST(pwm),
		.POWER_GOOD_OUT(pg), .HIGH_SIDE_ON(hs), .LOW_SIDE_ON(ls), .SOFT_DISCHARGE_ON(dis));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask

	task automatic chk(input logic [3:0] exp, input logic [3:0] care = 4'hf);
		checks++;
		if (({pg, hs, ls, dis} & care) !== (exp & care)) begin
			mismatches++;
			$display("wrong value at %0t: outputs %b expected %b", $time, {pg, hs, ls, dis}, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (mismatches == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic toggle_en;
		en = 1'b0;
		tick(5);
		chk(4'h1);
		en = 1'b1;
		tick(6);
	endtask

	task automatic trips(input int n);
		@(posedge strobe);
		#5;
		valley = 1'b1;
		repeat (n) @(posedge strobe);
		#5;
		valley = 1'b0;
	endtask

	task automatic t_run;
		chk(4'hc);
		pwm = 1'b0;
		tick(4);
		chk(4'ha);
		pwm = 1'b1;
		stage_ok = 1'b0;
		tick(4);
		chk(4'h0, 4'h8);
		stage_ok = 1'b1;
		sup_ok = 1'b0;
		tick(4);
		chk(4'h0, 4'h8);
		sup_ok = 1'b1;
		tick(6);
		chk(4'hc);
	endtask

	task automatic t_uv;
		uv = 1'b1;
		tick(4);
		chk(4'h1);
		uv = 1'b0;
		tick(4);
		chk(4'h1);
		toggle_en;
		chk(4'hc);
	endtask

	task automatic t_ov;
		ov = 1'b1;
		above = 1'b1;
		tick(4);
		chk(4'h2);
		above = 1'b0;
		tick(4);
		chk(4'h0);
		above = 1'b1;
		ov = 1'b0;
		tick(4);
		chk(4'h2);
		above = 1'b0;
		toggle_en;
		chk(4'hc);
	endtask

	task automatic t_oc;
		trips(7);
		trips(7);
		tick(2);
		chk(4'hc);
		trips(8);
		tick(8);
		chk(4'h1);
		toggle_en;
		chk(4'hc);
	endtask

	task automatic t_hs_por;
		hs_oc = 1'b1;
		tick(4);
		hs_oc = 1'b0;
		tick(4);
		chk(4'h1);
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(6);
		chk(4'hc);
	endtask

	task automatic t_hot;
		temp = 8'h9b;
		tick(4);
		chk(4'h1);
		temp = 8'h8c;
		toggle_en;
		chk(4'h1);
		temp = 8'h19;
		tick(2);
		toggle_en;
		chk(4'hc);
	endtask

	initial begin
		{en, sup_ok, stage_ok, pwm} = 4'hf;
		{rst_n, uv, ov, above, hs_oc, valley} = 6'h00;
		temp = 8'h19;
		mismatches = 0;
		checks = 0;
		repeat (5) @(posedge clk);
		#5;
		chk(4'h1);
		rst_n = 1'b1;
		tick(6);
		t_run;
		t_uv;
		t_ov;
		t_oc;
		t_hs_por;
		t_hot;
		tally_and_finish;
	end

	initial begin
		#50us;
		mismatches++;
		tally_and_finish;
	end
endmodule // rfsup_top_tb
